// ### twbo_pkg.sv
/*
  three-wire bus ownership: shared constants, state and decode types.
  assumes a single 125 MHz bus clock domain.
*/
package twbo_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ADDR_W        = 28;
  localparam int unsigned N_CS          = 8;
  localparam int unsigned N_WE          = 4;
  localparam int unsigned N_RAS         = 2;
  localparam int unsigned N_CAS         = 4;
  localparam int unsigned WS_W          = 4;
  localparam int unsigned HI_ADDR_LSB   = 24;
  localparam logic [3:0]  HI_ADDR_ZERO  = 4'h0;
  localparam logic [WS_W-1:0] WS_RESET  = 4'h0;

  // gray coded along reset -> em -> implicit -> explicit
  typedef enum logic [1:0] {
    TWBO_RESET    = 2'b00,
    TWBO_EM_OWN   = 2'b01,
    TWBO_IMPLICIT = 2'b11,
    TWBO_EXPLICIT = 2'b10
  } twbo_state_e;

  typedef enum logic [1:0] {
    TWBO_SPACE_NONE = 2'b00,
    TWBO_SPACE_CS   = 2'b01,
    TWBO_SPACE_DRAM = 2'b10,
    TWBO_SPACE_DEF  = 2'b11
  } twbo_space_e;
endpackage

// ### twbo_sync.sv
/*
  three-flop pin synchroniser with agreement filter.
  assumes asynchronous input; output changes when stages two and three agree.
*/
`timescale 1ns/10ps
`default_nettype none
module twbo_sync #(
  parameter int unsigned W     = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_d,
  output var  logic [W-1:0] o_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      o_q  <= INIT;
    end else if (i_ce) begin
      s1_q <= i_d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int k = 0; k < W; k++) begin
        if (s2_q[k] == s3_q[k]) begin
          o_q[k] <= s2_q[k];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### twbo_arbiter.sv
/*
  bus ownership state machine plus external-master transfer snooping.
  assumes grant and transfer-start pins synchronised here; internal request, lock and memory decode
  hits come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// - any state enters reset while reset input or watchdog reset asserted
// - leaving reset: grant gives implicit, no grant gives external-master
// - implicit: undriven; request or lock gives explicit; no grant gives em
// - em state: grant with lock or request gives explicit, else implicit
// - explicit drives bus and bus-driven; other states drive nothing
// - explicit held while grant stays asserted
// - grant gone, lock clear: finish cycle then em; idle goes immediately
// - lock set keeps explicit ownership after grant removed
// - releasing bus negates bus-driven and floats address, data, control
// - end of cycle is any termination; split transfers count as one
// - bus request output registers internal request while grant, driven negated
// - em state may still assert chip selects, strobes, ack and request
// - transfer may begin the cycle after grant asserted
// - capture address, direction, size on edge transfer start sampled
// - upper four address bits read zero when pins are not address
// - transfer type, access type and mask attribute bits ignored
// - edge after capture starts chip select, write enables, optional ack
// - no address drive for chip-select or default memory transfers
// - dram hit asserts strobes, dram write, ack; address if drive bit
// - default memory: ack after programmed wait states if auto-ack set
module twbo_arbiter #(
  parameter int unsigned ADDR_W = twbo_pkg::ADDR_W,
  parameter int unsigned WS_W   = twbo_pkg::WS_W
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_ce,
  input  wire logic                          i_watchdog_rst,
  input  wire logic                          i_bus_grant_in_n,
  input  wire logic                          i_internal_bus_request,
  input  wire logic                          i_bus_lock_bit,
  input  wire logic                          i_xfer_in_progress,
  input  wire logic                          i_end_of_cycle,
  input  wire logic                          i_transfer_start_n,
  input  wire logic [ADDR_W-1:0]             i_addr,
  input  wire logic                          i_rd_wr_n,
  input  wire logic [1:0]                    i_transfer_size,
  input  wire logic                          i_hi_addr_is_addr,
  input  wire logic                          i_cs_hit,
  input  wire logic [twbo_pkg::N_CS-1:0]     i_cs_sel,
  input  wire logic                          i_cs_dir_ok,
  input  wire logic                          i_cs_auto_ack,
  input  wire logic                          i_dram_hit,
  input  wire logic [twbo_pkg::N_RAS-1:0]    i_dram_bank,
  input  wire logic                          i_dram_dir_ok,
  input  wire logic                          i_dram_address_drive_bit,
  input  wire logic                          i_def_auto_ack,
  input  wire logic [WS_W-1:0]               i_wait_state_count,
  output var  logic [1:0]                    o_state,
  output var  logic                          o_bus_driven_out_n,
  output var  logic                          o_bus_oe_n,
  output var  logic                          o_bus_request_out_n,
  output var  logic [ADDR_W-1:0]             o_cap_addr,
  output var  logic                          o_cap_rd_wr_n,
  output var  logic [1:0]                    o_cap_size,
  output var  logic [twbo_pkg::N_CS-1:0]     o_cs_n,
  output var  logic [twbo_pkg::N_WE-1:0]     o_we_n,
  output var  logic [twbo_pkg::N_RAS-1:0]    o_ras_n,
  output var  logic [twbo_pkg::N_CAS-1:0]    o_cas_n,
  output var  logic                          o_dram_write_n,
  output var  logic                          o_dram_addr_oe_n,
  output var  logic                          o_transfer_ack_n,
  output var  logic                          o_transfer_ack_oe_n
);
  import twbo_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic grant_n_s;
  logic ts_n_s;

  twbo_sync #(.W(2), .INIT(2'h3)) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_ce  (i_ce),
    .i_d   ({i_bus_grant_in_n, i_transfer_start_n}),
    .o_q   ({grant_n_s, ts_n_s})
  );

  logic grant;
  assign grant = ~grant_n_s;

  // ------------------------------------------------------------
  // arbitration state
  // ------------------------------------------------------------
  twbo_state_e state_q;
  twbo_state_e state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      TWBO_RESET: begin
        state_d = grant ? TWBO_IMPLICIT : TWBO_EM_OWN;
      end
      TWBO_IMPLICIT: begin
        if (!grant) begin
          state_d = TWBO_EM_OWN;
        end else if (i_bus_lock_bit || i_internal_bus_request) begin
          state_d = TWBO_EXPLICIT;
        end
      end
      TWBO_EXPLICIT: begin
        // grant or lock keeps ownership
        if (!grant && !i_bus_lock_bit) begin
          // leave idle at once or at end of the whole cycle
          if (!i_xfer_in_progress || i_end_of_cycle) begin
            state_d = TWBO_EM_OWN;
          end
        end
      end
      TWBO_EM_OWN: begin
        if (grant) begin
          state_d = (i_bus_lock_bit || i_internal_bus_request) ? TWBO_EXPLICIT
                                                                : TWBO_IMPLICIT;
        end
      end
      default: state_d = TWBO_RESET;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= TWBO_RESET;
    end else if (i_ce) begin
      if (i_watchdog_rst) begin
        state_q <= TWBO_RESET;
      end else begin
        state_q <= state_d;
      end
    end
  end

  logic explicit_d;
  assign explicit_d = (state_d == TWBO_EXPLICIT) && !i_watchdog_rst;

  // ------------------------------------------------------------
  // bus drive and request
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_state            <= TWBO_RESET;
      o_bus_driven_out_n <= 1'b1;
      o_bus_oe_n         <= 1'b1;
    end else if (i_ce) begin
      o_state            <= i_watchdog_rst ? TWBO_RESET : state_d;
      o_bus_driven_out_n <= ~explicit_d;
      o_bus_oe_n         <= ~explicit_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_bus_request_out_n <= 1'b1;
    end else if (i_ce) begin
      if (grant_n_s && o_bus_driven_out_n) begin
        o_bus_request_out_n <= ~i_internal_bus_request;
      end
    end
  end

  // ------------------------------------------------------------
  // external-master capture and decode
  // ------------------------------------------------------------
  logic        ts_prev_q;
  logic        cap_q;
  logic        em_xfer;
  logic        ts_edge;

  // only snoop while this device is not driving
  assign em_xfer = o_bus_driven_out_n;
  assign ts_edge = !ts_n_s && ts_prev_q && em_xfer;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ts_prev_q     <= 1'b1;
      cap_q         <= 1'b0;
      o_cap_addr    <= '0;
      o_cap_rd_wr_n <= 1'b1;
      o_cap_size    <= 2'h0;
    end else if (i_ce) begin
      ts_prev_q <= ts_n_s;
      cap_q     <= ts_edge;
      if (ts_edge) begin
        // type and attribute inputs not taken
        o_cap_addr    <= i_addr;
        o_cap_rd_wr_n <= i_rd_wr_n;
        o_cap_size    <= i_transfer_size;
        if (!i_hi_addr_is_addr) begin
          o_cap_addr[ADDR_W-1:HI_ADDR_LSB] <= HI_ADDR_ZERO;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // memory control sequence
  // ------------------------------------------------------------
  twbo_space_e space_q;
  logic [WS_W-1:0] ws_q;
  logic            ack_pend_q;

  logic [N_WE-1:0] we_mask;
  always_comb begin
    we_mask = '0;
    case (o_cap_size)
      2'h1:    we_mask[o_cap_addr[1:0]] = 1'b1;
      2'h2:    we_mask = o_cap_addr[1] ? 4'hC : 4'h3;
      default: we_mask = 4'hF;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      space_q             <= TWBO_SPACE_NONE;
      ws_q                <= WS_RESET;
      ack_pend_q          <= 1'b0;
      o_cs_n              <= '1;
      o_we_n              <= '1;
      o_ras_n             <= '1;
      o_cas_n             <= '1;
      o_dram_write_n      <= 1'b1;
      o_dram_addr_oe_n    <= 1'b1;
      o_transfer_ack_n    <= 1'b1;
      o_transfer_ack_oe_n <= 1'b1;
    end else if (i_ce) begin
      if (cap_q) begin
        // decode on the edge after capture
        ack_pend_q <= 1'b0;
        ws_q       <= i_wait_state_count;
        if (i_cs_hit) begin
          space_q <= i_cs_dir_ok ? TWBO_SPACE_CS : TWBO_SPACE_NONE;
          if (i_cs_dir_ok) begin
            o_cs_n     <= ~i_cs_sel;
            o_we_n     <= o_cap_rd_wr_n ? '1 : ~we_mask;
            ack_pend_q <= i_cs_auto_ack;
          end
        end else if (i_dram_hit) begin
          space_q <= i_dram_dir_ok ? TWBO_SPACE_DRAM : TWBO_SPACE_NONE;
          if (i_dram_dir_ok) begin
            o_ras_n          <= ~i_dram_bank;
            o_cas_n          <= ~we_mask;
            o_dram_write_n   <= o_cap_rd_wr_n;
            o_dram_addr_oe_n <= ~i_dram_address_drive_bit;
            ack_pend_q       <= 1'b1;
          end
        end else begin
          space_q    <= TWBO_SPACE_DEF;
          ack_pend_q <= i_def_auto_ack;
        end
        if (i_cs_hit ? (i_cs_dir_ok && i_cs_auto_ack)
                     : (i_dram_hit ? i_dram_dir_ok : i_def_auto_ack)) begin
          o_transfer_ack_oe_n <= 1'b0;
          o_transfer_ack_n    <= (i_wait_state_count != '0);
        end
      end else if (ack_pend_q) begin
        if (!o_transfer_ack_n) begin
          ack_pend_q       <= 1'b0;
          o_transfer_ack_n <= 1'b1;
          o_cs_n           <= '1;
          o_we_n           <= '1;
          o_ras_n          <= '1;
          o_cas_n          <= '1;
          o_dram_write_n   <= 1'b1;
          o_dram_addr_oe_n <= 1'b1;
          space_q          <= TWBO_SPACE_NONE;
        end else if (ws_q <= 1) begin
          o_transfer_ack_n <= 1'b0;
        end else begin
          ws_q <= ws_q - 1'b1;
        end
      end else begin
        // ack released: negated one cycle, then floated
        o_transfer_ack_oe_n <= o_transfer_ack_n ? 1'b1 : o_transfer_ack_oe_n;
        if (space_q != TWBO_SPACE_NONE && !cap_q) begin
          if (ts_n_s) begin
            o_cs_n           <= '1;
            o_we_n           <= '1;
            o_ras_n          <= '1;
            o_cas_n          <= '1;
            o_dram_write_n   <= 1'b1;
            o_dram_addr_oe_n <= 1'b1;
            space_q          <= TWBO_SPACE_NONE;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_wdog_reset: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_watchdog_rst) |=> (state_q == TWBO_RESET))
    else $error("watchdog did not force reset state");

  a_reset_exit: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && state_q == TWBO_RESET && !i_watchdog_rst) |=>
      (state_q == ($past(grant) ? TWBO_IMPLICIT : TWBO_EM_OWN)))
    else $error("wrong state after reset");

  a_impl_exit: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && !i_watchdog_rst && state_q == TWBO_IMPLICIT && grant
      && i_internal_bus_request) |=> (state_q == TWBO_EXPLICIT))
    else $error("implicit did not go explicit on request");

  a_em_grant: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && !i_watchdog_rst && state_q == TWBO_EM_OWN && grant
      && !i_bus_lock_bit && !i_internal_bus_request) |=> (state_q == TWBO_IMPLICIT))
    else $error("em with grant did not go implicit");

  a_drive_match: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_bus_driven_out_n == (o_state != TWBO_EXPLICIT)) && (o_bus_oe_n == o_bus_driven_out_n))
    else $error("bus driven does not match state");

  a_hold_grant: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && !i_watchdog_rst && state_q == TWBO_EXPLICIT && grant) |=>
      (state_q == TWBO_EXPLICIT))
    else $error("explicit left while granted");

  a_lock_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && !i_watchdog_rst && state_q == TWBO_EXPLICIT && i_bus_lock_bit) |=>
      (state_q == TWBO_EXPLICIT))
    else $error("explicit left while locked");

  a_release_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && !i_watchdog_rst && state_q == TWBO_EXPLICIT && !grant
      && !i_bus_lock_bit && !i_xfer_in_progress) |=> (state_q == TWBO_EM_OWN))
    else $error("idle release not immediate");

  a_capture: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && ts_edge) |=> (o_cap_size == $past(i_transfer_size)))
    else $error("size not captured");
endmodule
`default_nettype wire

// ### twbo_far_end.sv
/*
  far-end model: the external bus arbiter plus one external master.
  assumes bench commands change shortly after the rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module twbo_far_end (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_give_grant,
  input  wire logic        i_start,
  input  wire logic [27:0] i_addr,
  input  wire logic        i_rd_wr_n,
  input  wire logic [1:0]  i_size,
  input  wire logic        i_bus_driven_out_n,
  input  wire logic        i_transfer_ack_n,
  output var  logic        o_bus_grant_in_n,
  output var  logic        o_transfer_start_n,
  output var  logic [27:0] o_addr,
  output var  logic        o_rd_wr_n,
  output var  logic [1:0]  o_size,
  output var  logic        o_busy
);
  logic [3:0] cnt_q;

  // grant only while our own master is idle
  always_ff @(posedge i_clk) begin
    if (i_rst)
      o_bus_grant_in_n <= 1'b1;
    else
      o_bus_grant_in_n <= !(i_give_grant && !o_busy);
  end

  // released lines show the inverse of the last value, not a held copy
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_busy             <= 1'b0;
      o_transfer_start_n <= 1'b1;
      cnt_q              <= 4'h0;
    end else if (!o_busy) begin
      if (i_start && i_bus_driven_out_n) begin
        o_busy             <= 1'b1;
        o_transfer_start_n <= 1'b0;
        cnt_q              <= 4'h0;
        o_addr             <= (i_size == 2'h1) ? i_addr :
                              (i_size == 2'h2) ? {i_addr[27:1], 1'b0} :
                              {i_addr[27:2], 2'h0};
        o_rd_wr_n          <= i_rd_wr_n;
        o_size             <= i_size;
      end
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'h5)
        o_transfer_start_n <= 1'b1;
      if (!i_transfer_ack_n || cnt_q == 4'hF) begin
        o_busy             <= 1'b0;
        o_transfer_start_n <= 1'b1;
        o_addr             <= ~o_addr;
        o_rd_wr_n          <= ~o_rd_wr_n;
        o_size             <= ~o_size;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
/*
  self-checking bench for the bus ownership block.
  assumes the far-end model stands for the arbiter and external master.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import twbo_pkg::*;
  logic i_clk = 0, i_rst = 1, wd = 0, give = 0, start = 0, ireq = 0, lock = 0;
  logic xip = 0, eoc = 0, hi_is_addr = 1, rw = 1, cs_hit = 0, cs_dir = 0, cs_aa = 0;
  logic dr_hit = 0, dr_dir = 0, dr_drv = 0, def_aa = 0, busy, gnt_n, ts_n, m_rw, drv_n, br_n;
  logic [7:0] cs_sel = 8'h04, cs_n;
  logic [1:0] bank = 2'h2, sz = 2'h0, m_size, st, cap_size, ras_n;
  logic [3:0] ws = 4'h0, we_n, cas_n;
  logic [27:0] addr = 28'h0, m_addr, cap_addr;
  logic oe_n, cap_rw, dw_n, da_oe_n, ack_n, ack_oe_n;
  int n_fail = 0;
  int checked = 0;

  always #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;

  twbo_far_end u_twbo_far_end (.i_clk(i_clk), .i_rst(i_rst), .i_give_grant(give),
    .i_start(start), .i_addr(addr), .i_rd_wr_n(rw), .i_size(sz),
    .i_bus_driven_out_n(drv_n), .i_transfer_ack_n(ack_n), .o_bus_grant_in_n(gnt_n),
    .o_transfer_start_n(ts_n), .o_addr(m_addr), .o_rd_wr_n(m_rw), .o_size(m_size),
    .o_busy(busy));

  twbo_arbiter u_twbo_arbiter (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
    .i_watchdog_rst(wd), .i_bus_grant_in_n(gnt_n), .i_internal_bus_request(ireq),
    .i_bus_lock_bit(lock), .i_xfer_in_progress(xip), .i_end_of_cycle(eoc),
    .i_transfer_start_n(ts_n), .i_addr(m_addr), .i_rd_wr_n(m_rw), .i_transfer_size(m_size),
    .i_hi_addr_is_addr(hi_is_addr), .i_cs_hit(cs_hit), .i_cs_sel(cs_sel),
    .i_cs_dir_ok(cs_dir), .i_cs_auto_ack(cs_aa), .i_dram_hit(dr_hit), .i_dram_bank(bank),
    .i_dram_dir_ok(dr_dir), .i_dram_address_drive_bit(dr_drv), .i_def_auto_ack(def_aa),
    .i_wait_state_count(ws), .o_state(st), .o_bus_driven_out_n(drv_n), .o_bus_oe_n(oe_n),
    .o_bus_request_out_n(br_n), .o_cap_addr(cap_addr), .o_cap_rd_wr_n(cap_rw),
    .o_cap_size(cap_size), .o_cs_n(cs_n), .o_we_n(we_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
    .o_dram_write_n(dw_n), .o_dram_addr_oe_n(da_oe_n), .o_transfer_ack_n(ack_n),
    .o_transfer_ack_oe_n(ack_oe_n));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wait_st(input logic [1:0] s);
    int k;
    k = 0;
    while (st !== s && k < 12) begin
      tick();
      k++;
    end
  endtask

  task automatic launch(input logic [27:0] a, input logic w_n, input logic [27:0] ec);
    int k;
    addr = a;
    rw = w_n;
    start = 1'b1;
    tick();
    start = 1'b0;
    k = 0;
    while (cap_addr !== ec && k < 12) begin
      tick();
      k++;
    end
    chk(cap_addr, ec);
    chk(cap_rw, w_n);
    chk(cap_size, sz);
  endtask

  // counts edges from capture to acknowledge, then lets the master go idle
  task automatic finish(output int lat);
    int k;
    lat = 0;
    while (ack_n !== 1'b0 && lat < 20) begin
      tick();
      lat++;
    end
    k = 0;
    while (busy && k < 30) begin
      tick();
      k++;
    end
    tick(6);
  endtask

  task automatic conclude;
    $display("counts: checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_implicit;
    give = 1'b1;
    wait_st(TWBO_IMPLICIT);
    chk(st, TWBO_IMPLICIT);
    wd = 1'b1;
    tick(2);
    chk(st, TWBO_RESET);
    wd = 1'b0;
    tick(2);
    chk(st, TWBO_IMPLICIT);
    chk({drv_n, oe_n}, 2'h3);
    lock = 1'b1;
    tick(2);
    chk(st, TWBO_EXPLICIT);
    chk({drv_n, oe_n}, 2'h0);
    give = 1'b0;
    tick(8);
    chk({st, drv_n}, {TWBO_EXPLICIT, 1'b0});
    lock = 1'b0;
    tick(2);
    chk(st, TWBO_EM_OWN);
    chk({drv_n, oe_n}, 2'h3);
    $display("test implicit done");
  endtask

  task automatic t_explicit;
    ireq = 1'b1;
    tick(2);
    chk(br_n, 1'b0);
    give = 1'b1;
    wait_st(TWBO_EXPLICIT);
    chk(st, TWBO_EXPLICIT);
    ireq = 1'b0;
    tick(20);
    chk(st, TWBO_EXPLICIT);
    chk(br_n, 1'b0);
    xip = 1'b1;
    give = 1'b0;
    tick(8);
    chk({st, drv_n}, {TWBO_EXPLICIT, 1'b0});
    eoc = 1'b1;
    tick();
    eoc = 1'b0;
    xip = 1'b0;
    tick(2);
    chk({st, drv_n}, {TWBO_EM_OWN, 1'b1});
    tick(2);
    chk(br_n, 1'b1);
    $display("test explicit done");
  endtask

  task automatic t_chip_select;
    int lat;
    cs_hit = 1'b1;
    cs_dir = 1'b1;
    cs_aa = 1'b1;
    hi_is_addr = 1'b0;
    launch(28'hA123450, 1'b0, 28'h0123450);
    tick();
    chk({cs_n, we_n}, 12'hFB0);
    chk({ack_n, ack_oe_n, oe_n}, 3'h1);
    tick();
    chk(ack_n, 1'b1);
    tick();
    chk(ack_oe_n, 1'b1);
    finish(lat);
    sz = 2'h1;
    launch(28'h0123452, 1'b0, 28'h0123452);
    tick();
    chk({cs_n, we_n}, 12'hFBB);
    finish(lat);
    chk(lat, 0);
    sz = 2'h2;
    launch(28'h0123462, 1'b0, 28'h0123462);
    tick();
    chk({cs_n, we_n}, 12'hFB3);
    finish(lat);
    chk(lat, 0);
    sz = 2'h0;
    launch(28'h0123470, 1'b1, 28'h0123470);
    tick();
    chk({cs_n, we_n}, 12'hFBF);
    finish(lat);
    chk(lat, 0);
    cs_dir = 1'b0;
    hi_is_addr = 1'b1;
    launch(28'hB000010, 1'b1, 28'hB000010);
    tick();
    chk(cs_n, 8'hFF);
    finish(lat);
    chk(lat, 20);
    cs_hit = 1'b0;
    $display("test chip select done");
  endtask

  task automatic t_dram;
    int lat;
    dr_hit = 1'b1;
    dr_dir = 1'b1;
    dr_drv = 1'b1;
    launch(28'h0200020, 1'b0, 28'h0200020);
    tick();
    chk({ras_n, cas_n, dw_n, da_oe_n}, 8'h40);
    finish(lat);
    chk(lat, 0);
    dr_drv = 1'b0;
    launch(28'h0300030, 1'b1, 28'h0300030);
    tick();
    chk({ras_n, dw_n, da_oe_n}, 4'h7);
    finish(lat);
    dr_hit = 1'b0;
    $display("test dram done");
  endtask

  task automatic t_default;
    int lat;
    logic [3:0] tbl [3] = '{4'h0, 4'h3, 4'h7};
    def_aa = 1'b1;
    for (int i = 0; i < 3; i++) begin
      ws = tbl[i];
      launch(28'h0400000 + 28'(i * 16), 1'b1, 28'h0400000 + 28'(i * 16));
      finish(lat);
      chk(lat, 1 + tbl[i]);
    end
    def_aa = 1'b0;
    launch(28'h0500040, 1'b0, 28'h0500040);
    chk(oe_n, 1'b1);
    finish(lat);
    chk(lat, 20);
    $display("test default memory done");
  endtask

  initial begin
    tick(16);
    chk({st, drv_n, cs_n, ack_n}, {TWBO_RESET, 1'b1, 8'hFF, 1'b1});
    i_rst = 1'b0;
    tick(3);
    chk(st, TWBO_EM_OWN);
    t_implicit();
    t_explicit();
    t_chip_select();
    t_dram();
    t_default();
    conclude();
  end

  initial begin
    #(CLK_PERIOD_NS * 4000);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
